//--- design/hsg_top.sv
`timescale 1ns/1ps
`include "hsg_regs.svh"
// Functional notes
// (RQ1) actuator select: 0 DC output, 1 AC
// (RQ2) AC half period is divider plus one ticks
// (RQ3) system tick divided from a core clock
// (RQ4) rate code below 1000 uses sync clock
// (RQ5) software keeps divider within 100 to 250 Hz
// (RQ6) first level is signed eight-bit, resets zero
// (RQ7) level sets DC value or AC peak, sign inverts
// (RQ8) first length counts 0.625 ms steps, zero skips
// (RQ9) second level drives continuous and phase two
// (RQ10) second length is eleven-bit step count
// (RQ11) third level is signed eight-bit final level
// (RQ12) third length is nine-bit step count
// (RQ13) status reads one while profile runs
// (RQ14) status reads zero otherwise, resets zero
// (RQ15) mode field: off, continuous, one-shot, reserved
// (RQ16) trigger write runs phases one, two, three
// (RQ17) continuous mode uses only second level
// (RQ18) profile end gives zero; retrigger restarts
// (RQ19) one sample per request; off gives zero
module hsg_top #(
  parameter int SYNC_DIV = 1, // core clock edges per sync system tick
  parameter int ASYNC_DIV = 1, // core clock edges per async system tick
  parameter int STEP_CYCLES = `HSG_STEP_NS / `HSG_CLK_NS // one duration step
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_sync_core_clock,
  input wire logic i_async_core_clock,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_sample_req,
  output logic [15:0] o_sample_data,
  output logic o_sample_valid,
  output logic o_irq
);

  if (STEP_CYCLES < 2 || STEP_CYCLES > 65535) begin : g_bad_step
    $error("hsg_top: bad STEP_CYCLES");
  end

  // reset release synchroniser
  logic rst_meta; // first stage, read only by rst_n
  logic rst_n; // reset used by the rest of the design

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software registers
  logic act_sel; // actuator_type_select
  hsg_pkg::hsg_mode_t mode; // generator_mode_select
  logic [14:0] freq_div; // resonant_freq_divider
  logic [7:0] lvl1; // first_phase_level
  logic [8:0] len1; // first_phase_length
  logic [7:0] lvl2; // second_phase_level
  logic [10:0] len2; // second_phase_length
  logic [7:0] lvl3; // third_phase_level
  logic [8:0] len3; // third_phase_length
  logic [3:0] rate_code; // generator_sample_rate_code
  logic [1:0] irq_sts; // sticky event flags
  logic [1:0] irq_msk; // event enables

  // address decode
  wire wr_ctrl = i_wr && (i_addr == `HSG_OFS_CTRL);
  wire wr_freq = i_wr && (i_addr == `HSG_OFS_FREQ);
  wire wr_lvl1 = i_wr && (i_addr == `HSG_OFS_LVL1);
  wire wr_len1 = i_wr && (i_addr == `HSG_OFS_LEN1);
  wire wr_lvl2 = i_wr && (i_addr == `HSG_OFS_LVL2);
  wire wr_len2 = i_wr && (i_addr == `HSG_OFS_LEN2);
  wire wr_lvl3 = i_wr && (i_addr == `HSG_OFS_LVL3);
  wire wr_len3 = i_wr && (i_addr == `HSG_OFS_LEN3);
  wire wr_rate = i_wr && (i_addr == `HSG_OFS_RATE);
  wire wr_ists = i_wr && (i_addr == `HSG_OFS_ISTS);
  wire wr_imsk = i_wr && (i_addr == `HSG_OFS_IMSK);

  // mode field as written in this cycle
  wire [1:0] wr_mode = i_wdata[`HSG_CTRL_MODE_LSB +: 2];

  // trigger only counts when the written mode is one-shot
  wire trigger = wr_ctrl && i_wdata[`HSG_CTRL_TRIG_BIT]
                 && (wr_mode == hsg_pkg::HSG_MODE_ONESHOT); // see RQ16

  // control register: trigger bit is write-only and reads zero
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_sel <= 1'b0;
      mode <= hsg_pkg::HSG_MODE_OFF;
    end else if (wr_ctrl) begin
      act_sel <= i_wdata[`HSG_CTRL_ACT_BIT]; // see RQ1
      mode <= hsg_pkg::hsg_mode_t'(wr_mode); // see RQ15
    end
  end

  // frequency divider and sample rate code
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_div <= `HSG_RST_FREQ; // see RQ2
      rate_code <= `HSG_RST_RATE;
    end else begin
      if (wr_freq) freq_div <= i_wdata[14:0];
      if (wr_rate) rate_code <= i_wdata[3:0];
    end
  end

  // phase levels, signed eight-bit
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl1 <= `HSG_RST_LVL; // see RQ6
      lvl2 <= `HSG_RST_LVL;
      lvl3 <= `HSG_RST_LVL;
    end else begin
      if (wr_lvl1) lvl1 <= i_wdata[7:0]; // see RQ6
      if (wr_lvl2) lvl2 <= i_wdata[7:0]; // see RQ9
      if (wr_lvl3) lvl3 <= i_wdata[7:0]; // see RQ11
    end
  end

  // phase lengths in duration steps
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      len1 <= `HSG_RST_LEN1;
      len2 <= `HSG_RST_LEN2;
      len3 <= `HSG_RST_LEN3;
    end else begin
      if (wr_len1) len1 <= i_wdata[8:0]; // see RQ8
      if (wr_len2) len2 <= i_wdata[10:0]; // see RQ10
      if (wr_len3) len3 <= i_wdata[8:0]; // see RQ12
    end
  end

  // system tick sources, one per core clock
  logic sync_tick; // divided synchronous core clock
  logic async_tick; // divided asynchronous core clock

  hsg_clk_div #(.DIV(SYNC_DIV)) u_sync_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_core_clock(i_sync_core_clock),
    .o_tick(sync_tick)
  ); // see RQ3

  hsg_clk_div #(.DIV(ASYNC_DIV)) u_async_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_core_clock(i_async_core_clock),
    .o_tick(async_tick)
  ); // see RQ3

  // clock source follows the rate code
  wire use_async = (rate_code >= `HSG_RATE_ASYNC_MIN); // see RQ4
  wire sys_tick = use_async ? async_tick : sync_tick; // see RQ4

  // AC tone: half period of freq_div+1 system ticks
  logic [14:0] half_cnt; // ticks within the half period
  logic ac_low; // second half of the tone period
  wire half_done = (half_cnt >= freq_div); // a lowered divider must not strand the count

  // tone phase accumulator
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 15'h0000;
      ac_low <= 1'b0;
    end else if (sys_tick) begin
      if (half_done) begin
        half_cnt <= 15'h0000; // see RQ2
        ac_low <= ~ac_low; // see RQ2
      end else begin
        half_cnt <= half_cnt + 15'h0001;
      end
    end
  end

  // one-shot profile sequencer
  hsg_pkg::hsg_state_t state; // current phase
  hsg_pkg::hsg_state_t next_state; // phase after the current one
  logic [10:0] remaining; // steps left in the current phase
  logic [10:0] next_len; // length to load for next_state
  logic [15:0] step_cnt; // reference cycles within a step
  wire step_done = (step_cnt == 16'(STEP_CYCLES - 1));
  wire running = (state != hsg_pkg::HSG_ST_IDLE);
  wire phase_over = running && (remaining == 11'h000);
  wire profile_done = phase_over && (state == hsg_pkg::HSG_ST_PH3);

  // phase order and length of the following phase
  always_comb begin
    next_state = hsg_pkg::HSG_ST_IDLE;
    next_len = 11'h000;
    unique case (state)
      hsg_pkg::HSG_ST_IDLE: begin
        next_state = hsg_pkg::HSG_ST_IDLE;
      end
      hsg_pkg::HSG_ST_PH1: begin
        next_state = hsg_pkg::HSG_ST_PH2; // see RQ16
        next_len = len2;
      end
      hsg_pkg::HSG_ST_PH2: begin
        next_state = hsg_pkg::HSG_ST_PH3; // see RQ16
        next_len = {2'b00, len3};
      end
      hsg_pkg::HSG_ST_PH3: begin
        next_state = hsg_pkg::HSG_ST_IDLE; // see RQ18
      end
    endcase
  end

  // phase state and step counting
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hsg_pkg::HSG_ST_IDLE;
      remaining <= 11'h000;
      step_cnt <= 16'h0000;
    end else if (trigger) begin
      // a trigger always restarts from phase one
      state <= hsg_pkg::HSG_ST_PH1; // see RQ18
      remaining <= {2'b00, len1}; // see RQ8
      step_cnt <= 16'h0000;
    end else if (mode != hsg_pkg::HSG_MODE_ONESHOT) begin
      // leaving one-shot mode abandons the profile
      state <= hsg_pkg::HSG_ST_IDLE;
      step_cnt <= 16'h0000;
    end else if (phase_over) begin
      // zero length phases pass in a single cycle
      state <= next_state; // see RQ16
      remaining <= next_len;
      step_cnt <= 16'h0000;
    end else if (running) begin
      if (step_done) begin
        step_cnt <= 16'h0000;
        remaining <= remaining - 11'h001; // see RQ10
      end else begin
        step_cnt <= step_cnt + 16'h0001;
      end
    end
  end

  // level for the current mode and phase
  logic [7:0] active_lvl; // signed level feeding the output
  logic lvl_on; // output active at all

  always_comb begin
    active_lvl = 8'h00;
    lvl_on = 1'b0;
    unique case (mode)
      hsg_pkg::HSG_MODE_CONT: begin
        active_lvl = lvl2; // see RQ17
        lvl_on = 1'b1;
      end
      hsg_pkg::HSG_MODE_ONESHOT: begin
        lvl_on = running;
        unique case (state)
          hsg_pkg::HSG_ST_PH1: active_lvl = lvl1; // see RQ6
          hsg_pkg::HSG_ST_PH2: active_lvl = lvl2; // see RQ9
          hsg_pkg::HSG_ST_PH3: active_lvl = lvl3; // see RQ11
          hsg_pkg::HSG_ST_IDLE: active_lvl = 8'h00; // see RQ18
        endcase
      end
      // off and reserved codes give silence
      hsg_pkg::HSG_MODE_OFF, hsg_pkg::HSG_MODE_RSVD: begin
        lvl_on = 1'b0; // see RQ19
      end
    endcase
  end

  // nine-bit signed amplitude so that full negative scale can flip
  wire [8:0] amp_ext = {active_lvl[7], active_lvl};
  wire [8:0] amp_neg = 9'(~amp_ext + 9'h001);
  wire flip = act_sel && ac_low; // see RQ7
  wire [8:0] amp = lvl_on ? (flip ? amp_neg : amp_ext) : 9'h000; // see RQ7
  wire [15:0] sample_word = {amp, 7'h00};

  // one sample per request from the mixer
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sample_data <= 16'h0000;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= i_sample_req; // see RQ19
      if (i_sample_req) o_sample_data <= sample_word; // see RQ19
    end
  end

  // sticky events: start and finish of a profile, set beats clear
  wire [1:0] irq_evt = {trigger, profile_done};
  wire [1:0] irq_clr = wr_ists ? i_wdata[1:0] : 2'b00;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts <= 2'b00;
      irq_msk <= 2'b00;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | irq_evt;
      if (wr_imsk) irq_msk <= i_wdata[1:0];
    end
  end

  // level interrupt while an enabled flag stands
  wire [1:0] irq_live = irq_sts & irq_msk; // flags allowed to interrupt
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) o_irq <= 1'b0;
    else o_irq <= |irq_live;
  end

  // read multiplexer, unmapped offsets read zero
  wire [15:0] ctrl_rd = {11'h000, 1'b0, mode, act_sel, 1'b0};
  wire [15:0] stat_rd = {15'h0000, running}; // see RQ13
  logic [15:0] rd_mux;

  always_comb begin
    unique case (i_addr)
      `HSG_OFS_CTRL: rd_mux = ctrl_rd;
      `HSG_OFS_FREQ: rd_mux = {1'b0, freq_div};
      `HSG_OFS_LVL1: rd_mux = {8'h00, lvl1};
      `HSG_OFS_LEN1: rd_mux = {7'h00, len1};
      `HSG_OFS_LVL2: rd_mux = {8'h00, lvl2};
      `HSG_OFS_LEN2: rd_mux = {5'h00, len2};
      `HSG_OFS_LVL3: rd_mux = {8'h00, lvl3};
      `HSG_OFS_LEN3: rd_mux = {7'h00, len3};
      `HSG_OFS_STAT: rd_mux = stat_rd; // see RQ14
      `HSG_OFS_RATE: rd_mux = {12'h000, rate_code};
      `HSG_OFS_ISTS: rd_mux = {14'h0000, irq_sts};
      `HSG_OFS_IMSK: rd_mux = {14'h0000, irq_msk};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) o_rdata <= 16'h0000;
    else o_rdata <= i_rd ? rd_mux : 16'h0000;
  end

endmodule : hsg_top

//--- design/hsg_regs.svh
`ifndef HSG_REGS_SVH
`define HSG_REGS_SVH

// register offsets (8-bit word address)
`define HSG_OFS_CTRL 8'h90
`define HSG_OFS_FREQ 8'h91
`define HSG_OFS_LVL1 8'h92
`define HSG_OFS_LEN1 8'h93
`define HSG_OFS_LVL2 8'h94
`define HSG_OFS_LEN2 8'h95
`define HSG_OFS_LVL3 8'h96
`define HSG_OFS_LEN3 8'h97
`define HSG_OFS_STAT 8'h98
`define HSG_OFS_RATE 8'h99
`define HSG_OFS_ISTS 8'h9A
`define HSG_OFS_IMSK 8'h9B

// control register fields
`define HSG_CTRL_TRIG_BIT 4
`define HSG_CTRL_MODE_LSB 2
`define HSG_CTRL_ACT_BIT 1

// reset values
`define HSG_RST_FREQ 15'h7FFF
`define HSG_RST_LVL 8'h00
`define HSG_RST_LEN1 9'h000
`define HSG_RST_LEN2 11'h000
`define HSG_RST_LEN3 9'h000
`define HSG_RST_RATE 4'h0

// rate codes at or above this use the asynchronous core clock
`define HSG_RATE_ASYNC_MIN 4'h8

// interrupt status bit positions
`define HSG_IRQ_DONE_BIT 0
`define HSG_IRQ_START_BIT 1

// duration step and reference clock period, in ns
`define HSG_STEP_NS 625000
`define HSG_CLK_NS 40

`endif

//--- design/hsg_pkg.sv
package hsg_pkg;

  // generator operating mode
  typedef enum logic [1:0] {
    HSG_MODE_OFF = 2'b00,
    HSG_MODE_CONT = 2'b01,
    HSG_MODE_ONESHOT = 2'b10,
    HSG_MODE_RSVD = 2'b11
  } hsg_mode_t;

  // one-shot profile phase
  typedef enum logic [1:0] {
    HSG_ST_IDLE = 2'b00,
    HSG_ST_PH1 = 2'b01,
    HSG_ST_PH2 = 2'b10,
    HSG_ST_PH3 = 2'b11
  } hsg_state_t;

endpackage : hsg_pkg

//--- design/hsg_clk_div.sv
`timescale 1ns/1ps
// syncs a core clock pin, then divides its rising edges into a tick pulse
module hsg_clk_div #(
  parameter int DIV = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_core_clock,
  output logic o_tick
);

  if (DIV < 1 || DIV > 65536) begin : g_bad_div
    $error("hsg_clk_div: DIV out of range for the 16-bit counter");
  end

  logic sync_a; // first stage, read only by sync_b
  logic sync_b; // second stage
  logic sync_c; // delayed copy for edge detection
  logic [15:0] div_cnt; // edge counter
  wire rise = sync_b & ~sync_c;
  wire wrap = (div_cnt == 16'(DIV - 1));

  // two-stage synchroniser plus edge history
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= i_core_clock;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // integer division of the core clock edges
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      o_tick <= rise & wrap;
      if (rise) begin
        div_cnt <= wrap ? 16'h0000 : div_cnt + 16'h0001;
      end
    end
  end

endmodule : hsg_clk_div

//--- verif/hsg_top_properties.sv
`timescale 1ns/1ps
// watches bus, sample stream and interrupt of the generator
module hsg_chk (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_sample_req,
  input wire logic [15:0] o_sample_data,
  input wire logic o_sample_valid,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic start_en; // shadow of the start-event mask bit
  // trigger write with one-shot mode
  wire trig = i_wr && i_addr == 8'h90 && i_wdata[4] && i_wdata[3:2] == 2'b10;
  // follow writes to the mask register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_en <= 1'b0;
    end else if (i_wr && i_addr == 8'h9B) begin
      start_en <= i_wdata[1];
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  a_valid_follows: assert property (i_sample_req |=> o_sample_valid)
    else $error("no sample after request");
  a_valid_cause: assert property (o_sample_valid |-> $past(i_sample_req))
    else $error("sample without request");
  a_data_hold: assert property (!o_sample_valid |-> $stable(o_sample_data))
    else $error("sample changed between requests");
  a_data_pad: assert property (o_sample_valid |-> o_sample_data[6:0] == 7'h00)
    else $error("sample low bits not zero");
  a_status_width: assert property (i_rd && i_addr == 8'h98 |=> o_rdata[15:1] == 15'h0000)
    else $error("status upper bits set");
  a_trig_reads0: assert property (i_rd && i_addr == 8'h90 |=> !o_rdata[4])
    else $error("trigger bit read back");
  a_off_zero: assert property (i_wr && i_addr == 8'h90 && i_wdata[3:2] == 2'b00
    ##1 i_sample_req |=> o_sample_data == 16'h0000)
    else $error("disabled generator not silent");
  a_mask_quiet: assert property (i_wr && i_addr == 8'h9B && i_wdata[1:0] == 2'b00
    |=> ##1 !o_irq)
    else $error("masked interrupt raised");
  a_start_irq: assert property (trig && start_en |-> ##[1:3] o_irq)
    else $error("start event gave no interrupt");
endmodule : hsg_chk
bind hsg_top hsg_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_sample_req(i_sample_req), .o_sample_data(o_sample_data),
  .o_sample_valid(o_sample_valid), .o_irq(o_irq));

//--- verif/hsg_mixer_model.sv
`timescale 1ns/1ps
// stands in for the output mixer: pulls samples, counts sign changes
module hsg_mixer_model (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_run, // pull samples while high
  input wire logic [1:0] i_gap, // idle cycles between requests
  input wire logic i_valid,
  input wire logic [15:0] i_data,
  output logic o_req,
  output logic [15:0] o_flips
);
  logic [1:0] wait_cnt; // cycles left before next request
  logic sign; // sign of the previous sample
  // request pacing, prompt or slow
  always @(posedge i_ref_clk) begin
    if (!i_reset_n || !i_run) begin
      o_req <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == 2'h0) begin
      o_req <= 1'b1;
      wait_cnt <= i_gap;
    end else begin
      o_req <= 1'b0;
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
  // count sign changes of delivered samples
  always @(posedge i_ref_clk) begin
    if (!i_run) begin
      o_flips <= 16'h0000;
      sign <= 1'b0;
    end else if (i_valid) begin
      sign <= i_data[15];
      if (i_data[15] != sign) o_flips <= o_flips + 16'h0001;
    end
  end
endmodule : hsg_mixer_model

//--- verif/hsg_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for the haptic generator
module hsg_top_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sync_clk = 1'b0; // core clocks, 5 MHz and about 4.2 MHz
  logic async_clk = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic req;
  logic [15:0] sdata;
  logic svalid;
  logic irq;
  logic run = 1'b0; // mixer pulls samples
  logic [1:0] gap = 2'h0;
  logic [15:0] flips;
  int err_count = 0;
  int check_count = 0;
  always #20 ref_clk = ~ref_clk;
  initial #10 forever #100 sync_clk = ~sync_clk; // kept off the reference edges
  always #120 async_clk = ~async_clk;
  // one duration step is 4 cycles here
  hsg_top #(.STEP_CYCLES(4)) DUT (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
    .i_sync_core_clock(sync_clk), .i_async_core_clock(async_clk), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sample_req(req),
    .o_sample_data(sdata), .o_sample_valid(svalid), .o_irq(irq));
  hsg_mixer_model u_mix (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_run(run),
    .i_gap(gap), .i_valid(svalid), .i_data(sdata), .o_req(req), .o_flips(flips));
  // expected sample for a level
  function automatic logic [15:0] smp(input logic [7:0] l);
    return {l[7], l, 7'h00};
  endfunction : smp
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  task automatic t_regs;
    logic [15:0] d;
    logic [15:0] msk [9];
    msk = '{16'h0, 16'h7FFF, 16'hFF, 16'h1FF, 16'hFF, 16'h7FF, 16'hFF, 16'h1FF, 16'h0};
    rd_reg(8'h90, d);
    chk(d & 16'h001E, 16'h0000);
    for (int k = 1; k < 9; k++) begin
      rd_reg(8'h90 + 8'(k), d);
      chk(d, (k == 1) ? 16'h7FFF : 16'h0000);
      wr_reg(8'h90 + 8'(k), 16'hFFFF);
      rd_reg(8'h90 + 8'(k), d);
      chk(d, msk[k]);
    end
    wr_reg(8'h91, 16'h2FFF);
    rd_reg(8'h91, d);
    chk(d, 16'h2FFF);
    wr_reg(8'h80, 16'h1234);
    rd_reg(8'h80, d);
    chk(d, 16'h0000);
    $display("register test done");
  endtask : t_regs
  task automatic t_dc;
    wr_reg(8'h92, 16'h0010);
    wr_reg(8'h96, 16'h0030);
    wr_reg(8'h94, 16'h0040);
    wr_reg(8'h90, 16'h0004);
    gap <= 2'h2;
    run <= 1'b1;
    wait_cyc(10);
    chk(sdata, smp(8'h40));
    wr_reg(8'h94, 16'h00C0);
    wait_cyc(10);
    chk(sdata, smp(8'hC0));
    wr_reg(8'h90, 16'h000C);
    wait_cyc(10);
    chk(sdata, 16'h0000);
    wr_reg(8'h90, 16'h0004);
    wait_cyc(10);
    chk(sdata, smp(8'hC0));
    wr_reg(8'h90, 16'h0000);
    wait_cyc(10);
    chk(sdata, 16'h0000);
    run <= 1'b0;
    $display("dc test done");
  endtask : t_dc
  task automatic t_ac(input logic [3:0] r, input logic [15:0] dv, input int lo, input int hi);
    wr_reg(8'h94, 16'h0040);
    wr_reg(8'h91, dv);
    wr_reg(8'h99, {12'h000, r});
    wr_reg(8'h90, 16'h0006);
    gap <= 2'h0;
    run <= 1'b1;
    wait_cyc(240);
    chk(16'(flips >= lo && flips <= hi), 16'h0001);
    chk(16'(sdata == 16'h2000 || sdata == 16'hE000), 16'h0001);
    run <= 1'b0;
    wr_reg(8'h90, 16'h0000);
    $display("ac test done");
  endtask : t_ac
  task automatic t_shot;
    logic [15:0] d;
    int n1;
    int n2;
    int n3;
    n1 = 0;
    n2 = 0;
    n3 = 0;
    wr_reg(8'h92, 16'h0010);
    wr_reg(8'h93, 16'h0001);
    wr_reg(8'h94, 16'h0020);
    wr_reg(8'h95, 16'h0002);
    wr_reg(8'h96, 16'h00F0);
    wr_reg(8'h97, 16'h0000);
    wr_reg(8'h9A, 16'h0003);
    wr_reg(8'h9B, 16'h0003);
    gap <= 2'h0;
    run <= 1'b1;
    wr_reg(8'h90, 16'h0018);
    // phase lengths are step count times four plus one
    for (int c = 0; c < 40; c++) begin
      wait_cyc(1);
      if (svalid === 1'b1 && sdata === smp(8'h10)) n1++;
      if (svalid === 1'b1 && sdata === smp(8'h20)) n2++;
      if (svalid === 1'b1 && sdata === smp(8'hF0)) n3++;
    end
    chk(16'(n1), 16'h0005);
    chk(16'(n2), 16'h0009);
    chk(16'(n3), 16'h0001);
    chk(sdata, 16'h0000);
    run <= 1'b0;
    rd_reg(8'h98, d);
    chk(d, 16'h0000);
    chk({15'h0, irq}, 16'h0001);
    rd_reg(8'h9A, d);
    chk(d, 16'h0003);
    wr_reg(8'h9A, 16'h0003);
    wait_cyc(2);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(8'h9B, 16'h0000);
    wr_reg(8'h90, 16'h0018);
    wait_cyc(30);
    chk({15'h0, irq}, 16'h0000);
    rd_reg(8'h9A, d);
    chk(d, 16'h0003);
    wr_reg(8'h9A, 16'h0003);
    $display("one-shot test done");
  endtask : t_shot
  task automatic t_abort;
    logic [15:0] d;
    wr_reg(8'h95, 16'h07FF);
    gap <= 2'h0;
    run <= 1'b1;
    wr_reg(8'h90, 16'h0018);
    wait_cyc(20);
    chk(sdata, smp(8'h20));
    rd_reg(8'h98, d);
    chk(d, 16'h0001);
    wr_reg(8'h90, 16'h0018);
    wait_cyc(2);
    chk(sdata, smp(8'h10));
    wr_reg(8'h90, 16'h0004);
    rd_reg(8'h98, d);
    chk(d, 16'h0000);
    chk(sdata, smp(8'h20));
    run <= 1'b0;
    wr_reg(8'h90, 16'h0000);
    $display("abort test done");
  endtask : t_abort
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // cut a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_dc();
    t_ac(4'h7, 16'h0001, 23, 25);
    t_ac(4'h8, 16'h0001, 19, 21);
    t_ac(4'h0, 16'h0002, 15, 17);
    t_shot();
    t_abort();
    print_verdict();
  end
endmodule : hsg_top_tb
